// file: src/lcm_addr_map.sv
// Purpose: classify a core data or short-form I/O access into region selects
// Assumes: compat is stable while accesses run
// Notes: purely combinational, the top registers the result
`timescale 1ns/1ps
`default_nettype none
module lcm_addr_map (
    input wire logic compat,
    input wire lcm_pkg::lcm_access_s acc,
    output lcm_pkg::lcm_decode_s dec
);
    import lcm_pkg::*;

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // ------------------------------------------------------------
    // Region decode
    // ------------------------------------------------------------
    always_comb begin
        dec = '0;
        if (acc.valid && acc.is_io) begin
            dec.legacy_io = (acc.addr < IO_SPACE_SIZE);
        end else if (acc.valid) begin
            dec.legacy_io = in_range(acc.addr, IO_BASE, IO_TOP);
            dec.ext_io = in_range(acc.addr, EXT_IO_BASE, EXT_IO_TOP) && !compat;
            if (compat && in_range(acc.addr, RAM_BASE_LEGACY, 16'hFFFF)) begin
                dec.ram = 1'b1;
                dec.ram_off = acc.addr - RAM_BASE_LEGACY;
            end else if (!compat && in_range(acc.addr, RAM_BASE_NORMAL, 16'hFFFF)) begin
                dec.ram = 1'b1;
                dec.ram_off = acc.addr - RAM_BASE_NORMAL;
            end
        end
    end
endmodule : lcm_addr_map
`default_nettype wire

// file: src/lcm_compat_gate.sv
// Purpose: fuse-selected legacy compatibility gating of map, vectors and peripherals
// Assumes: AHB-Lite master issues single word transfers, one slave
// Notes: fuse is caught once at the first edge after reset release
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Extra I/O registers decode at data addresses 0x60 to 0xFF.
// - Extended locations answer data loads and stores, never short I/O accesses.
// - Inherited I/O registers keep their old places in the 64 I/O slots.
// - Mode comes from the programmed fuse, not from a writable register.
// - Compat mode disables extended I/O and places RAM at the legacy base.
// - Compat mode drops extended vectors, leaving only the legacy table.
// - Compat mode offers one USART, asynchronous only.
// - Compat mode exposes only the low eight baud divisor bits.
// - Compat mode offers one 16-bit timer with two compare registers.
// - Compat mode removes the two-wire interface.
// - Compat mode forces the third port to output only.
// - Compat mode leaves the seventh port with alternate functions only.
// - Compat mode makes the analog port digital input only, no drive.
// - Compat mode removes the boot loader.
// - Compat mode ignores oscillator trim writes.
// - Compat mode forbids address pin release and per-section wait states.
// - Compat mode keeps only external and power-on reset flags.
// - Compat mode changes watchdog timeout without the timed unlock.
// - Compat mode forces external interrupts 3..0 to level sensing.
// - Compat mode has no receive FIFO, overrun on first overwrite.
module lcm_compat_gate (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic legacy_compat_fuse,
    input wire lcm_pkg::lcm_access_s cpu_acc,
    output lcm_pkg::lcm_decode_s acc_dec,
    input wire logic vec_req,
    input wire logic [5:0] vec_num,
    output logic vec_ok,
    input wire lcm_pkg::lcm_port_s port_req,
    output lcm_pkg::lcm_port_s port_eff,
    output lcm_pkg::lcm_feat_s feat,
    output logic [11:0] baud_div,
    output logic [7:0] osc_trim,
    output logic [2:0] wdt_timeout,
    output logic wdt_enable,
    output logic [7:0] eint_sense,
    input wire logic [4:0] reset_cause,
    input wire logic rx_byte_valid,
    input wire logic rx_byte_read,
    output logic rx_overrun
);
    import lcm_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic compat;
    logic fuse_done;
    logic wr_pend;
    logic [7:0] wr_off;
    logic [7:0] feat_req;
    logic [11:0] baud_reg;
    logic [4:0] csr;
    logic [7:0] sense_reg;
    logic [3:0] wdt_cnt;
    logic [1:0] rx_cnt;
    logic [1:0] rx_depth;
    lcm_wdt_e wdt_state;
    lcm_decode_s dec_comb;
    logic addr_ph;
    logic addr_hit;
    logic [4:0] csr_keep;
    logic [4:0] next_csr;
    logic [1:0] next_rx_cnt;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic wr_at(input logic pend, input logic [7:0] off,
                                   input logic [7:0] target);
        wr_at = pend && (off == target);
    endfunction : wr_at

    function automatic logic [31:0] reg_read(input logic [7:0] off, input logic cm,
                                             input logic ovr, input logic [7:0] fr,
                                             input logic [11:0] bd, input logic [7:0] ot,
                                             input logic [4:0] cs, input logic [4:0] wd,
                                             input logic [7:0] es);
        reg_read = 32'h0000_0000;
        unique case (off)
            OFF_STATUS: reg_read = {29'h0, ovr, cm, cm};
            OFF_FEAT_REQ: reg_read = {24'h0, fr};
            OFF_BAUD: reg_read = {20'h0, bd};
            OFF_OSC_TRIM: reg_read = {24'h0, ot};
            OFF_MCU_CSR: reg_read = {27'h0, cs};
            OFF_WDT_CTRL: reg_read = {27'h0, wd};
            OFF_EXT_SENSE: reg_read = {24'h0, es};
            default: reg_read = 32'h0000_0000;
        endcase
    endfunction : reg_read

    // ------------------------------------------------------------
    // Fuse capture
    // ------------------------------------------------------------
    // fuse sets mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compat <= COMPAT_RST;
            fuse_done <= 1'b0;
        end else if (!fuse_done) begin
            compat <= legacy_compat_fuse;
            fuse_done <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Zero wait states; the master never overlaps a read with a write data phase
    assign addr_ph = hsel && htrans[1] && hready;
    assign addr_hit = (haddr[31:8] == 24'h0);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_off <= 8'h00;
        end else begin
            wr_pend <= addr_ph && hwrite && addr_hit;
            wr_off <= {haddr[7:2], 2'b00};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ph && !hwrite) begin
            hrdata <= addr_hit ? reg_read({haddr[7:2], 2'b00}, compat, rx_overrun, feat_req,
                                          baud_reg, osc_trim, csr,
                                          {wdt_state == WDT_OPEN, wdt_enable, wdt_timeout},
                                          sense_reg) : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            feat_req <= FEAT_REQ_RST;
            sense_reg <= EXT_SENSE_RST;
        end else begin
            if (wr_at(wr_pend, wr_off, OFF_FEAT_REQ)) begin
                feat_req <= hwdata[7:0];
            end
            if (wr_at(wr_pend, wr_off, OFF_EXT_SENSE)) begin
                sense_reg <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            baud_reg <= BAUD_RST;
        end else if (wr_at(wr_pend, wr_off, OFF_BAUD)) begin
            baud_reg[7:0] <= hwdata[7:0];
            if (!compat) begin
                baud_reg[11:8] <= hwdata[11:8];
            end
        end
    end

    assign baud_div = compat ? {4'h0, baud_reg[7:0]} : baud_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_trim <= OSC_TRIM_RST;
        end else if (wr_at(wr_pend, wr_off, OFF_OSC_TRIM) && !compat) begin
            osc_trim <= hwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Reset flags
    // ------------------------------------------------------------
    // legacy flag subset
    assign csr_keep = compat ? CSR_LEGACY_MASK : 5'h1F;
    always_comb begin
        next_csr = csr;
        if (wr_at(wr_pend, wr_off, OFF_MCU_CSR)) begin
            next_csr = csr & hwdata[4:0];
        end
        // Set beats a clearing write in the same cycle
        next_csr = (next_csr | reset_cause) & csr_keep;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            csr <= CSR_RST;
        end else begin
            csr <= next_csr;
        end
    end

    // ------------------------------------------------------------
    // Watchdog timeout change
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_state <= WDT_LOCKED;
            wdt_cnt <= 4'h0;
            wdt_timeout <= 3'h0;
            wdt_enable <= 1'b0;
        end else begin
            unique case (wdt_state)
                WDT_LOCKED: begin
                    if (wr_at(wr_pend, wr_off, OFF_WDT_CTRL) && compat) begin
                        wdt_timeout <= hwdata[2:0];
                        wdt_enable <= hwdata[WDT_EN];
                    end else if (wr_at(wr_pend, wr_off, OFF_WDT_CTRL)) begin
                        // Enabling alone is always allowed; CE with EN opens the unlock window; anything else waits for unlock
                        if (hwdata[WDT_CE] && hwdata[WDT_EN]) begin
                            wdt_state <= WDT_OPEN;
                            wdt_cnt <= WDT_UNLOCK_CYC;
                        end else if (hwdata[WDT_EN]) begin
                            wdt_enable <= 1'b1;
                        end
                    end
                end
                WDT_OPEN: begin
                    wdt_cnt <= wdt_cnt - 4'h1;
                    if (wr_at(wr_pend, wr_off, OFF_WDT_CTRL)) begin
                        wdt_timeout <= hwdata[2:0];
                        wdt_enable <= hwdata[WDT_EN];
                        wdt_state <= WDT_LOCKED;
                    end else if (wdt_cnt == 4'h1) begin
                        wdt_state <= WDT_LOCKED;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receive holding and overrun
    // ------------------------------------------------------------
    // one holding byte in compat mode, two in normal mode
    assign rx_depth = compat ? RX_DEPTH_LEGACY : RX_DEPTH_NORMAL;
    always_comb begin
        next_rx_cnt = rx_cnt;
        if (rx_byte_read && rx_cnt != 2'h0) begin
            next_rx_cnt = next_rx_cnt - 2'h1;
        end
        if (rx_byte_valid && next_rx_cnt < rx_depth) begin
            next_rx_cnt = next_rx_cnt + 2'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_cnt <= 2'h0;
            rx_overrun <= 1'b0;
        end else begin
            rx_cnt <= next_rx_cnt;
            if (rx_byte_valid && rx_cnt == rx_depth && !rx_byte_read) begin
                rx_overrun <= 1'b1;
            end else if (rx_byte_read) begin
                rx_overrun <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Map, vectors and feature gating
    // ------------------------------------------------------------
    lcm_addr_map u_map (
        .compat(compat),
        .acc(cpu_acc),
        .dec(dec_comb)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_dec <= '0;
            vec_ok <= 1'b0;
        end else begin
            acc_dec <= dec_comb;
            vec_ok <= vec_req && (!compat || vec_num < LEGACY_VEC_COUNT);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            feat <= '0;
            port_eff <= '0;
            eint_sense <= EXT_SENSE_RST;
        end else begin
            feat.usart1_en <= feat_req[FR_USART1] && !compat;
            feat.usart_sync_ok <= feat_req[FR_SYNC] && !compat;
            feat.baud_hi_ok <= !compat;
            feat.timer3_en <= feat_req[FR_TIMER3] && !compat;
            feat.compare_c_en <= feat_req[FR_CMP_C] && !compat;
            feat.twi_en <= feat_req[FR_TWI] && !compat;
            feat.boot_en <= feat_req[FR_BOOT] && !compat;
            feat.osc_trim_ok <= !compat;
            feat.xmem_release_ok <= feat_req[FR_XREL] && !compat;
            feat.xmem_wait_ok <= feat_req[FR_XWAIT] && !compat;
            feat.wdt_timed_req <= !compat;
            feat.rx_fifo_en <= !compat;
            feat.ext_vectors_en <= !compat;
            port_eff.portc_dir <= compat ? 8'hFF : port_req.portc_dir;
            port_eff.portf_oe <= compat ? 8'h00 : port_req.portf_oe;
            port_eff.portg_gpio <= compat ? 5'h00 : port_req.portg_gpio;
            eint_sense <= compat ? 8'h00 : sense_reg;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ext_io_gate_a: assert property (
        cpu_acc.valid && !cpu_acc.is_io && compat && fuse_done
        && cpu_acc.addr >= EXT_IO_BASE && cpu_acc.addr <= EXT_IO_TOP
        |=> !acc_dec.ext_io && acc_dec.ram) else $error("extended I/O reached in compat mode");
    ext_io_map_a: assert property (
        cpu_acc.valid && !cpu_acc.is_io && !compat && fuse_done
        && cpu_acc.addr >= EXT_IO_BASE && cpu_acc.addr <= EXT_IO_TOP
        |=> acc_dec.ext_io && !acc_dec.ram) else $error("extended I/O not decoded");
    short_io_a: assert property (
        cpu_acc.valid && cpu_acc.is_io |=> !acc_dec.ext_io)
        else $error("short I/O access reached extended region");
    vector_gate_a: assert property (
        vec_req && compat && vec_num >= LEGACY_VEC_COUNT |=> !vec_ok)
        else $error("extended vector allowed in compat mode");
    baud_high_a: assert property (
        compat && wr_at(wr_pend, wr_off, OFF_BAUD) |=> baud_div[11:8] == 4'h0
        && baud_div[7:0] == $past(hwdata[7:0])) else $error("baud write wrong in compat mode");
    port_force_a: assert property (
        compat && fuse_done ##1 compat |-> port_eff.portc_dir == 8'hFF
        && port_eff.portf_oe == 8'h00) else $error("port direction not forced");
    trim_hold_a: assert property (
        compat && wr_at(wr_pend, wr_off, OFF_OSC_TRIM) |=> $stable(osc_trim))
        else $error("oscillator trim changed in compat mode");
    csr_mask_a: assert property (
        compat && fuse_done |=> (csr & ~CSR_LEGACY_MASK) == 5'h00)
        else $error("extra reset flag in compat mode");
    wdt_direct_a: assert property (
        compat && wr_at(wr_pend, wr_off, OFF_WDT_CTRL)
        |=> wdt_timeout == $past(hwdata[2:0])) else $error("watchdog change refused");
    rx_overrun_a: assert property (
        compat && rx_cnt == RX_DEPTH_LEGACY && rx_byte_valid && !rx_byte_read
        |=> rx_overrun) else $error("overrun not flagged");
    twi_off_a: assert property (
        compat ##1 compat |-> !feat.twi_en && !feat.usart1_en && !feat.boot_en)
        else $error("removed feature still enabled");

    cover_ext_ram_c: cover property (compat ##1 acc_dec.ram && acc_dec.ram_off == 16'h0000);
    cover_wdt_open_c: cover property (wdt_state == WDT_OPEN ##[1:8] wdt_state == WDT_LOCKED);
    cover_overrun_c: cover property ($rose(rx_overrun));
endmodule : lcm_compat_gate
`default_nettype wire

// file: src/lcm_pkg.sv
// Purpose: shared constants and types for the legacy compatibility gating block
// Assumes: 8-bit core data space with 16-bit addresses, 32-bit AHB-Lite register bus
// Notes: register offsets are byte addresses on the bus
package lcm_pkg;
    // ------------------------------------------------------------
    // Data space map
    // ------------------------------------------------------------
    localparam logic [15:0] IO_BASE = 16'h0020;
    localparam logic [15:0] IO_TOP = 16'h005F;
    localparam logic [15:0] EXT_IO_BASE = 16'h0060;
    localparam logic [15:0] EXT_IO_TOP = 16'h00FF;
    localparam logic [15:0] IO_SPACE_SIZE = 16'h0040;
    localparam logic [15:0] RAM_BASE_LEGACY = 16'h0060;
    localparam logic [15:0] RAM_BASE_NORMAL = 16'h0100;
    localparam logic [5:0] LEGACY_VEC_COUNT = 6'h18;
    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_FEAT_REQ = 8'h04;
    localparam logic [7:0] OFF_BAUD = 8'h08;
    localparam logic [7:0] OFF_OSC_TRIM = 8'h0C;
    localparam logic [7:0] OFF_MCU_CSR = 8'h10;
    localparam logic [7:0] OFF_WDT_CTRL = 8'h14;
    localparam logic [7:0] OFF_EXT_SENSE = 8'h18;
    localparam logic [7:0] FEAT_REQ_RST = 8'hFF;
    localparam logic [11:0] BAUD_RST = 12'h000;
    localparam logic [7:0] OSC_TRIM_RST = 8'h80;
    localparam logic [4:0] CSR_RST = 5'h00;
    localparam logic [4:0] CSR_LEGACY_MASK = 5'h03;
    localparam logic [7:0] EXT_SENSE_RST = 8'h00;
    localparam logic COMPAT_RST = 1'b1;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned FR_USART1 = 0;
    localparam int unsigned FR_SYNC = 1;
    localparam int unsigned FR_TIMER3 = 2;
    localparam int unsigned FR_CMP_C = 3;
    localparam int unsigned FR_TWI = 4;
    localparam int unsigned FR_BOOT = 5;
    localparam int unsigned FR_XREL = 6;
    localparam int unsigned FR_XWAIT = 7;
    localparam int unsigned CSR_POR = 0;
    localparam int unsigned CSR_EXT = 1;
    localparam int unsigned WDT_CE = 4;
    localparam int unsigned WDT_EN = 3;
    // ------------------------------------------------------------
    // Timing and depths
    // ------------------------------------------------------------
    localparam logic [3:0] WDT_UNLOCK_CYC = 4'h8;
    localparam logic [1:0] RX_DEPTH_NORMAL = 2'h2;
    localparam logic [1:0] RX_DEPTH_LEGACY = 2'h1;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WDT_LOCKED = 2'b01,
        WDT_OPEN = 2'b10
    } lcm_wdt_e;
    typedef struct packed {
        logic valid;
        logic is_io;
        logic [15:0] addr;
    } lcm_access_s;
    typedef struct packed {
        logic legacy_io;
        logic ext_io;
        logic ram;
        logic [15:0] ram_off;
    } lcm_decode_s;
    typedef struct packed {
        logic usart1_en;
        logic usart_sync_ok;
        logic baud_hi_ok;
        logic timer3_en;
        logic compare_c_en;
        logic twi_en;
        logic boot_en;
        logic osc_trim_ok;
        logic xmem_release_ok;
        logic xmem_wait_ok;
        logic wdt_timed_req;
        logic rx_fifo_en;
        logic ext_vectors_en;
    } lcm_feat_s;
    typedef struct packed {
        logic [7:0] portc_dir;
        logic [7:0] portf_oe;
        logic [4:0] portg_gpio;
    } lcm_port_s;
endpackage : lcm_pkg

// file: test/testbench.sv
// Purpose: self-checking bench for the legacy compatibility gate
// Assumes: zero-wait AHB-Lite slave, fuse held steady across each reset
// Notes: every result goes through one queue of expected values
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lcm_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, hready, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, pval = 0, e;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2, wdt_timeout;
    logic legacy_compat_fuse = 1, vec_req = 0, vec_ok, wdt_enable, rd_ph = 0, pv = 0;
    logic rx_byte_valid = 0, rx_byte_read = 0, rx_overrun;
    logic [5:0] vec_num = 0;
    logic [4:0] reset_cause = 0;
    logic [7:0] osc_trim, eint_sense;
    logic [11:0] baud_div;
    lcm_access_s cpu_acc = '0;
    lcm_decode_s acc_dec;
    lcm_port_s port_req = '0, port_eff;
    lcm_feat_s feat;
    logic [31:0] q[$];
    int n_mismatch = 0, checked = 0, seed = 7;
    assign hready = hreadyout;
    always #4 hclk = ~hclk;
    lcm_compat_gate u_lcm_compat_gate (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .legacy_compat_fuse(legacy_compat_fuse), .cpu_acc(cpu_acc), .acc_dec(acc_dec),
        .vec_req(vec_req), .vec_num(vec_num), .vec_ok(vec_ok), .port_req(port_req),
        .port_eff(port_eff), .feat(feat), .baud_div(baud_div), .osc_trim(osc_trim),
        .wdt_timeout(wdt_timeout), .wdt_enable(wdt_enable), .eint_sense(eint_sense),
        .reset_cause(reset_cause), .rx_byte_valid(rx_byte_valid),
        .rx_byte_read(rx_byte_read), .rx_overrun(rx_overrun)
    );
    // ------------------------------------------------------------
    // Checking side
    // ------------------------------------------------------------
    always @(posedge hclk) begin
        if (rd_ph || pv) begin
            e = q.pop_front();
            checked++;
            if ((rd_ph ? hrdata : pval) !== e) begin
                $display("unexpected at %0t: got %h expected %h", $time,
                         rd_ph ? hrdata : pval, e);
                n_mismatch++;
            end
        end
    end
    // Idle edge after each check, so back-to-back checks never retoggle pv
    task chk(input logic [31:0] o, input logic [31:0] x);
        q.push_back(x);
        pval <= o;
        pv <= 1;
        @(posedge hclk);
        pv <= 0;
        @(posedge hclk);
    endtask : chk
    // Address phase held until hready, data phase likewise
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= !w;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        rd_ph <= 0;
    endtask : bus
    task rd(input logic [31:0] a, input logic [31:0] x);
        q.push_back(x);
        bus(0, a, 0);
    endtask : rd
    // Extra edge so the written value has landed
    task wr(input logic [31:0] a, input logic [31:0] d);
        bus(1, a, d);
        @(posedge hclk);
    endtask : wr
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    task run(input logic f);
        logic [11:0] b;
        b = 12'($random(seed));
        hresetn <= 0;
        legacy_compat_fuse <= f;
        repeat (6) @(posedge hclk);
        hresetn <= 1;
        repeat (3) @(posedge hclk);
        rd(OFF_STATUS, {30'h0, f, f});
        rd(OFF_FEAT_REQ, 32'hFF);
        chk(feat, f ? 13'h0 : 13'h1FFF);
        wr(OFF_BAUD, b);
        rd(OFF_BAUD, f ? b[7:0] : b);
        chk(baud_div, f ? b[7:0] : b);
        wr(OFF_OSC_TRIM, b[7:0]);
        rd(OFF_OSC_TRIM, f ? 8'h80 : b[7:0]);
        wr(OFF_WDT_CTRL, 8'h0D);
        chk({wdt_enable, wdt_timeout}, f ? 4'hD : 4'h8);
        // Normal mode needs the unlock window, compat takes both writes directly
        wr(OFF_WDT_CTRL, 32'h18);
        wr(OFF_WDT_CTRL, 32'h0B);
        chk({wdt_enable, wdt_timeout}, 4'hB);
        wr(OFF_EXT_SENSE, 8'hFF);
        // Sense output sits one register behind the written value
        @(posedge hclk);
        chk(eint_sense, f ? 8'h00 : 8'hFF);
        reset_cause <= 5'h1F;
        @(posedge hclk);
        reset_cause <= 0;
        rd(OFF_MCU_CSR, f ? 5'h03 : 5'h1F);
        cpu_acc <= '{1'b1, 1'b0, 16'h0060};
        repeat (2) @(posedge hclk);
        chk({acc_dec.ext_io, acc_dec.ram, acc_dec.ram_off},
            f ? 18'h10000 : 18'h20000);
        cpu_acc <= '{1'b1, 1'b1, 16'h0030};
        vec_req <= 1;
        vec_num <= 6'h18;
        port_req <= 21'($random(seed));
        repeat (2) @(posedge hclk);
        chk({acc_dec.legacy_io, acc_dec.ext_io}, 2'b10);
        chk(vec_ok, !f);
        chk(port_eff, f ? 21'h1FE000 : port_req);
        cpu_acc <= '0;
        vec_req <= 0;
        // Two bytes back to back, not read until after the status check
        rx_byte_valid <= 1;
        repeat (2) @(posedge hclk);
        rx_byte_valid <= 0;
        @(posedge hclk);
        rd(OFF_STATUS, f ? 3'h7 : 3'h0);
        rx_byte_read <= 1;
        @(posedge hclk);
        rx_byte_read <= 0;
        rd(OFF_STATUS, {30'h0, f, f});
        rd(32'h100, 0);
        chk({hresp, hreadyout}, 2'b01);
    endtask : run
    task finish_test;
        $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        run(1);
        run(0);
        finish_test;
    end
    initial begin
        repeat (2000) @(posedge hclk);
        n_mismatch++;
        finish_test;
    end
endmodule : testbench
`default_nettype wire
